// *** core/fbs_params.svh ***
/*
 * Constants of the fieldbus state and status block: register byte offsets,
 * field positions, reset values and host mode codes.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef FBS_PARAMS_SVH
`define FBS_PARAMS_SVH

`define FBS_ADDR_W          5
`define FBS_OFF_CTRL        5'h00
`define FBS_OFF_FLAGS       5'h04
`define FBS_OFF_IRQ_STATUS  5'h08
`define FBS_OFF_IRQ_CLEAR   5'h0c
`define FBS_OFF_IRQ_ENABLE  5'h10

`define FBS_CTRL_REQ_LSB    0
`define FBS_CTRL_REQ_MSB    1
`define FBS_CTRL_EMU_BIT    2
`define FBS_CTRL_HOST_LSB   4
`define FBS_CTRL_HOST_MSB   5
`define FBS_CTRL_W          6
`define FBS_CTRL_RST        6'h00

`define FBS_FLG_DEVERR      0
`define FBS_FLG_OFFLINE     1
`define FBS_FLG_STOPPED     2
`define FBS_FLG_CLEAR       3
`define FBS_FLG_OPERATE     4
`define FBS_FLG_EMU         5
`define FBS_FLG_HOSTRUN     6

`define FBS_IRQ_STATE       0
`define FBS_IRQ_DEVERR      1
`define FBS_IRQ_HOST        2
`define FBS_IRQ_W           3
`define FBS_IRQ_RST         3'h0

`define FBS_HOST_PROGRAM    2'h0
`define FBS_HOST_RUN        2'h1
`define FBS_HOST_FAULT      2'h2

`define FBS_NODES           127

`endif

// *** core/fbs_pkg.sv ***
/*
 * Types of the fieldbus state and status block.
 * Assumes nothing of its surroundings.
 */
package fbs_pkg;

    typedef enum logic [1:0] {
        FBS_OFFLINE,
        FBS_STOPPED,
        FBS_CLEAR,
        FBS_OPERATE
    } fbs_state_type;

    typedef logic [3:0] fbs_flags_type;

    // One-hot flags: offline, stopped, clear, operate from bit 0 up
    function automatic fbs_flags_type fbs_state_flags(input fbs_state_type s);
        fbs_flags_type f;
        f = 4'h0;
        case (s)
            FBS_OFFLINE: f = 4'h1;
            FBS_STOPPED: f = 4'h2;
            FBS_CLEAR:   f = 4'h4;
            FBS_OPERATE: f = 4'h8;
            default:     f = 4'h1;
        endcase
        return f;
    endfunction

endpackage

// *** core/fbs_state_if.sv ***
/*
 * Carrier between the status top and the fieldbus state machine.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface fbs_state_if;
    logic [1:0]             reqCode;
    logic                   forceOffline;
    fbs_pkg::fbs_state_type state;
    fbs_pkg::fbs_flags_type flags;
    logic                   commEn;
    logic                   procEn;
    logic                   outEn;
    logic                   stateChanged;

    modport top (output reqCode, output forceOffline,
                 input state, input flags, input commEn, input procEn,
                 input outEn, input stateChanged);
    modport fsm (input reqCode, input forceOffline,
                 output state, output flags, output commEn, output procEn,
                 output outEn, output stateChanged);
endinterface

// *** core/fbs_state_fsm.sv ***
/*
 * Fieldbus state machine: holds one of offline, stopped, clear, operate
 * and derives the network gating levels from it.
 * Assumes the requested code is stable from a register.
 */
`timescale 1ns/1ps
`include "fbs_params.svh"
module fbs_state_fsm (
    input  wire logic  mclk,
    input  wire logic  nrst,
    fbs_state_if.fsm   sif
);
    fbs_pkg::fbs_state_type state_r;
    fbs_pkg::fbs_state_type state_nxt;
    fbs_pkg::fbs_flags_type flags_r;
    fbs_pkg::fbs_flags_type flags_nxt;
    logic                   changed_r;
    logic                   changed_nxt;

    always_comb begin
        if (sif.forceOffline) begin
            state_nxt = fbs_pkg::FBS_OFFLINE;
        end else begin
            case (sif.reqCode)
                2'h0:    state_nxt = fbs_pkg::FBS_OFFLINE;
                2'h1:    state_nxt = fbs_pkg::FBS_STOPPED;
                2'h2:    state_nxt = fbs_pkg::FBS_CLEAR;
                2'h3:    state_nxt = fbs_pkg::FBS_OPERATE;
                default: state_nxt = fbs_pkg::FBS_OFFLINE;
            endcase
        end
        flags_nxt   = fbs_pkg::fbs_state_flags(state_nxt);
        changed_nxt = (state_nxt != state_r);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r   <= fbs_pkg::FBS_OFFLINE;
            flags_r   <= 4'h1;
            changed_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            flags_r   <= flags_nxt;
            changed_r <= changed_nxt;
        end
    end

    assign sif.state        = state_r;
    assign sif.flags        = flags_r;
    assign sif.stateChanged = changed_r;
    assign sif.commEn       = ~flags_r[0];
    assign sif.procEn       = flags_r[2] | flags_r[3];
    assign sif.outEn        = flags_r[3];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_fault_forces_off: assert property (sif.forceOffline |=> flags_r == 4'h1)
        else $error("Link fault did not force offline");
    a_flags_onehot_fsm: assert property ($onehot(flags_r))
        else $error("State flags not one-hot");
endmodule

// *** core/fbs_status.sv ***
/*
 * Fieldbus master state and status block with an Avalon-MM register slave,
 * slave device error detection and a level interrupt.
 * Assumes per-node status vectors synchronous to mclk and one waitrequest
 * master holding each request until waitrequest is low.
 */
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "fbs_params.svh"
module fbs_status #(
    parameter int NODES = `FBS_NODES
) (
    input  wire logic                    mclk,
    input  wire logic                    nrst,
    input  wire logic [`FBS_ADDR_W-1:0]  avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic      [31:0]             avs_readdata,
    output logic                         avs_waitrequest,
    input  wire logic [NODES-1:0]        slaveExpected,
    input  wire logic [NODES-1:0]        slaveOnline,
    input  wire logic [NODES-1:0]        slaveExchanging,
    input  wire logic                    linkFault,
    output logic                         slaveDeviceErrorFlag,
    output logic                         busOfflineFlag,
    output logic                         busStoppedFlag,
    output logic                         busClearFlag,
    output logic                         busOperateFlag,
    output logic                         slaveEmulationFlag,
    output logic                         hostRunFlag,
    output logic                         busCommEnable,
    output logic                         procDataEnable,
    output logic                         outputDataEnable,
    output logic                         irq
);
    fbs_state_if sif ();

    logic [`FBS_CTRL_W-1:0] ctrl_r;
    logic [`FBS_CTRL_W-1:0] ctrl_nxt;
    logic [`FBS_IRQ_W-1:0]  irqStatus_r;
    logic [`FBS_IRQ_W-1:0]  irqStatus_nxt;
    logic [`FBS_IRQ_W-1:0]  irqEnable_r;
    logic [`FBS_IRQ_W-1:0]  irqEnable_nxt;
    logic [`FBS_IRQ_W-1:0]  irqEvents;
    logic [`FBS_IRQ_W-1:0]  irqClear;
    logic                   devErr_r;
    logic                   devErr_nxt;
    logic                   hostRun_r;
    logic                   hostRun_nxt;
    logic                   emu_r;
    logic                   emu_nxt;
    logic                   ack_r;
    logic                   ack_nxt;
    logic [31:0]            rdata_r;
    logic [31:0]            rdata_nxt;
    logic                   request;
    logic                   wrDone;
    logic [31:0]            flagWord;

    function automatic logic addrHit(input logic [`FBS_ADDR_W-1:0] a,
                                     input logic [`FBS_ADDR_W-1:0] off);
        return (a == off);
    endfunction

    fbs_state_fsm u_fsm (
        .mclk (mclk),
        .nrst (nrst),
        .sif  (sif)
    );

    assign sif.reqCode      = ctrl_r[`FBS_CTRL_REQ_MSB:`FBS_CTRL_REQ_LSB];
    assign sif.forceOffline = linkFault;

    // Bus handshake: one wait cycle per request
    assign request         = avs_read | avs_write;
    assign avs_waitrequest = request & ~ack_r;
    assign wrDone          = avs_write & ack_r & avs_byteenable[0];

    always_comb begin
        flagWord                    = 32'h0;
        flagWord[`FBS_FLG_DEVERR]   = devErr_r;
        flagWord[`FBS_FLG_OFFLINE]  = sif.flags[0];
        flagWord[`FBS_FLG_STOPPED]  = sif.flags[1];
        flagWord[`FBS_FLG_CLEAR]    = sif.flags[2];
        flagWord[`FBS_FLG_OPERATE]  = sif.flags[3];
        flagWord[`FBS_FLG_EMU]      = emu_r;
        flagWord[`FBS_FLG_HOSTRUN]  = hostRun_r;
    end

    always_comb begin
        ack_nxt   = request & ~ack_r;
        rdata_nxt = rdata_r;
        if (avs_read && !ack_r) begin
            rdata_nxt = 32'h0;
            if (addrHit(avs_address, `FBS_OFF_CTRL)) begin
                rdata_nxt[`FBS_CTRL_W-1:0] = ctrl_r;
            end else if (addrHit(avs_address, `FBS_OFF_FLAGS)) begin
                rdata_nxt = flagWord;
            end else if (addrHit(avs_address, `FBS_OFF_IRQ_STATUS)) begin
                rdata_nxt[`FBS_IRQ_W-1:0] = irqStatus_r;
            end else if (addrHit(avs_address, `FBS_OFF_IRQ_ENABLE)) begin
                rdata_nxt[`FBS_IRQ_W-1:0] = irqEnable_r;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_readdata = rdata_r;

    // Control and enable registers
    always_comb begin
        ctrl_nxt      = ctrl_r;
        irqEnable_nxt = irqEnable_r;
        irqClear      = `FBS_IRQ_W'(0);
        if (wrDone && addrHit(avs_address, `FBS_OFF_CTRL)) begin
            ctrl_nxt = avs_writedata[`FBS_CTRL_W-1:0];
        end
        if (wrDone && addrHit(avs_address, `FBS_OFF_IRQ_ENABLE)) begin
            irqEnable_nxt = avs_writedata[`FBS_IRQ_W-1:0];
        end
        if (wrDone && addrHit(avs_address, `FBS_OFF_IRQ_CLEAR)) begin
            irqClear = avs_writedata[`FBS_IRQ_W-1:0];
        end
    end

    // Status flags from slaves, host and emulation mode
    always_comb begin
        // any expected slave not online and exchanging
        devErr_nxt  = |(slaveExpected & ~(slaveOnline & slaveExchanging));
        hostRun_nxt = (ctrl_r[`FBS_CTRL_HOST_MSB:`FBS_CTRL_HOST_LSB] == `FBS_HOST_RUN);
        emu_nxt     = ctrl_r[`FBS_CTRL_EMU_BIT];
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r      <= `FBS_CTRL_RST;
            irqEnable_r <= `FBS_IRQ_RST;
            devErr_r    <= 1'b0;
            hostRun_r   <= 1'b0;
            emu_r       <= 1'b0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            irqEnable_r <= irqEnable_nxt;
            devErr_r    <= devErr_nxt;
            hostRun_r   <= hostRun_nxt;
            emu_r       <= emu_nxt;
        end
    end

    // Sticky events, set wins over clear
    always_comb begin
        irqEvents                  = `FBS_IRQ_W'(0);
        irqEvents[`FBS_IRQ_STATE]  = sif.stateChanged;
        irqEvents[`FBS_IRQ_DEVERR] = devErr_nxt & ~devErr_r;
        irqEvents[`FBS_IRQ_HOST]   = hostRun_nxt ^ hostRun_r;
        irqStatus_nxt              = (irqStatus_r & ~irqClear) | irqEvents;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irqStatus_r <= `FBS_IRQ_RST;
        end else begin
            irqStatus_r <= irqStatus_nxt;
        end
    end

    assign irq                  = |(irqStatus_r & irqEnable_r);
    assign slaveDeviceErrorFlag = devErr_r;
    assign busOfflineFlag       = sif.flags[0];
    assign busStoppedFlag       = sif.flags[1];
    assign busClearFlag         = sif.flags[2];
    assign busOperateFlag       = sif.flags[3];
    assign slaveEmulationFlag   = emu_r;
    assign hostRunFlag          = hostRun_r;
    assign busCommEnable        = sif.commEn;
    assign procDataEnable       = sif.procEn;
    assign outputDataEnable     = sif.outEn;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence ctrlWrite;
        wrDone && addrHit(avs_address, `FBS_OFF_CTRL);
    endsequence

    sequence emuSet;
        ##1 ctrl_r[`FBS_CTRL_EMU_BIT] ##1 slaveEmulationFlag;
    endsequence

    a_dev_err_set: assert property (
        |(slaveExpected & ~(slaveOnline & slaveExchanging)) |=> slaveDeviceErrorFlag)
        else $error("Device error not flagged");
    a_dev_err_clear: assert property (
        (slaveExpected & ~(slaveOnline & slaveExchanging)) == '0 |=> !slaveDeviceErrorFlag)
        else $error("Device error flagged without a faulty slave");
    a_offline_quiet: assert property (busOfflineFlag |-> !busCommEnable)
        else $error("Traffic enabled while offline");
    a_stopped_nodata: assert property (
        busStoppedFlag |-> busCommEnable && !procDataEnable)
        else $error("Process data enabled while stopped");
    a_clear_no_out: assert property (
        busClearFlag |-> procDataEnable && !outputDataEnable)
        else $error("Outputs enabled while clear");
    a_operate_full: assert property (
        busOperateFlag |-> busCommEnable && procDataEnable && outputDataEnable)
        else $error("Operate state without full exchange");
    a_state_onehot: assert property (
        $onehot({busOfflineFlag, busStoppedFlag, busClearFlag, busOperateFlag}))
        else $error("More or less than one state flag set");
    a_ctrl_req_state: assert property (
        ctrlWrite ##0 (avs_writedata[1:0] == 2'h3) ##1 !linkFault
        |=> busOperateFlag)
        else $error("Operate request not reached in two cycles");
    a_emu_follows: assert property (
        ctrlWrite ##0 avs_writedata[`FBS_CTRL_EMU_BIT] |-> emuSet)
        else $error("Slave emulation flag did not follow mode");
    a_host_run: assert property (
        ctrl_r[`FBS_CTRL_HOST_MSB:`FBS_CTRL_HOST_LSB] == `FBS_HOST_RUN |=> hostRunFlag)
        else $error("Host run not flagged");
    a_host_norun: assert property (
        ctrl_r[`FBS_CTRL_HOST_MSB:`FBS_CTRL_HOST_LSB] != `FBS_HOST_RUN |=> !hostRunFlag)
        else $error("Host run flagged outside run mode");
    a_wait_one: assert property (request && !ack_r |=> !avs_waitrequest || !request)
        else $error("Wait state longer than one cycle");

    // Bus and register checks
    a_ack_single: assert property (ack_r |=> !ack_r)
        else $error("Acknowledge held longer than one cycle");
    a_wait_first: assert property ($rose(request) |-> avs_waitrequest)
        else $error("New request answered without a wait cycle");
    a_clear_reads_0: assert property (
        avs_read && !ack_r && addrHit(avs_address, `FBS_OFF_IRQ_CLEAR)
        |=> avs_readdata == 32'h0)
        else $error("Clear register did not read as zero");
    a_flags_readback: assert property (
        avs_read && !ack_r && addrHit(avs_address, `FBS_OFF_FLAGS)
        |=> avs_readdata == $past(flagWord))
        else $error("Flag word read back wrong");
    a_flags_ro: assert property (wrDone && addrHit(avs_address, `FBS_OFF_FLAGS)
        |=> $stable(ctrl_r) && $stable(irqEnable_r))
        else $error("Write to read-only flags changed a register");
    a_enable_write: assert property (
        wrDone && addrHit(avs_address, `FBS_OFF_IRQ_ENABLE)
        |=> irqEnable_r == $past(avs_writedata[`FBS_IRQ_W-1:0]))
        else $error("Interrupt enable write lost");

    // State request, gating and emulation checks
    a_req_offline: assert property (
        ctrlWrite ##0 (avs_writedata[1:0] == 2'h0)
        |=> ##1 busOfflineFlag)
        else $error("Offline request not reached in two cycles");
    a_req_stopped: assert property (
        ctrlWrite ##0 (avs_writedata[1:0] == 2'h1) ##1 !linkFault
        |=> busStoppedFlag)
        else $error("Stopped request not reached in two cycles");
    a_req_clear: assert property (
        ctrlWrite ##0 (avs_writedata[1:0] == 2'h2) ##1 !linkFault
        |=> busClearFlag)
        else $error("Clear request not reached in two cycles");
    a_link_offline: assert property (linkFault |=> busOfflineFlag && !busCommEnable)
        else $error("Link fault left traffic enabled");
    a_proc_needs_comm: assert property (procDataEnable |-> busCommEnable)
        else $error("Process data enabled without traffic");
    a_out_operate: assert property (outputDataEnable |-> busOperateFlag)
        else $error("Outputs enabled outside operate");
    a_emu_clears: assert property (
        ctrlWrite ##0 !avs_writedata[`FBS_CTRL_EMU_BIT] |-> ##2 !slaveEmulationFlag)
        else $error("Slave emulation flag did not clear");

    // Interrupt checks
    a_deverr_irq: assert property (
        $rose(slaveDeviceErrorFlag) |-> irqStatus_r[`FBS_IRQ_DEVERR])
        else $error("Device error rise not latched");
    a_host_irq: assert property (
        $changed(hostRunFlag) |-> irqStatus_r[`FBS_IRQ_HOST])
        else $error("Host run change not latched");
    a_state_irq: assert property (sif.stateChanged |=> irqStatus_r[`FBS_IRQ_STATE])
        else $error("State change not latched");
    for (genvar i = 0; i < `FBS_IRQ_W; i++) begin : g_sticky
        a_event_wins: assert property (irqEvents[i] |=> irqStatus_r[i])
            else $error("Status event lost against a clear");
        a_bit_holds: assert property (irqStatus_r[i] && !irqClear[i] |=> irqStatus_r[i])
            else $error("Status bit dropped without a clear");
        a_clear_drops: assert property (irqClear[i] && !irqEvents[i] |=> !irqStatus_r[i])
            else $error("Status bit not cleared");
    end
endmodule

// *** test/fbs_slave_model.sv ***
/*
 * Partner model of the fieldbus slave nodes seen by the status block.
 * Assumes gating levels from the status block on the same clock.
 */
`timescale 1ns/1ps
module fbs_slave_model #(
    parameter int NODES = 8
) (
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic             busCommEnable,
    input  wire logic             procDataEnable,
    input  wire logic [NODES-1:0] cfgExpected,
    input  wire logic [NODES-1:0] nodePresent,
    input  wire logic [NODES-1:0] nodeFaulty,
    output logic      [NODES-1:0] slaveExpected,
    output logic      [NODES-1:0] slaveOnline,
    output logic      [NODES-1:0] slaveExchanging
);
    // Nodes come online only while the master talks and exchange only while it also exchanges data
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            slaveExpected   <= {NODES{1'b0}};
            slaveOnline     <= {NODES{1'b0}};
            slaveExchanging <= {NODES{1'b0}};
        end else begin
            slaveExpected   <= cfgExpected;
            slaveOnline     <= busCommEnable ? nodePresent : {NODES{1'b0}};
            slaveExchanging <= (busCommEnable && procDataEnable) ?
                               (nodePresent & ~nodeFaulty) : {NODES{1'b0}};
        end
    end
endmodule

// *** test/test_fbs_status.sv ***
/*
 * Testbench of the fieldbus state and status block.
 * Assumes one clock, an Avalon-MM master here and the slave node model.
 */
`timescale 1ns/1ps
`include "fbs_params.svh"
module test_fbs_status;
    localparam int N = 8;
    logic        mclk, nrst, avsRead, avsWrite, linkFault, irq, waitReq;
    logic [4:0]  avsAddr;
    logic [31:0] avsWdata, avsRdata, rdv;
    logic [N-1:0] cfgExpected, nodePresent, nodeFaulty, sExp, sOn, sEx;
    logic        devErr, offF, stopF, clrF, opF, emuF, hostF, commEn, procEn, outEn;
    int          error_cnt, checks, s, h;

    fbs_status #(.NODES(N)) u_fbs_status (.mclk(mclk), .nrst(nrst),
        .avs_address(avsAddr), .avs_read(avsRead), .avs_write(avsWrite),
        .avs_writedata(avsWdata), .avs_byteenable(4'hf), .avs_readdata(avsRdata),
        .avs_waitrequest(waitReq), .slaveExpected(sExp), .slaveOnline(sOn),
        .slaveExchanging(sEx), .linkFault(linkFault), .slaveDeviceErrorFlag(devErr),
        .busOfflineFlag(offF), .busStoppedFlag(stopF), .busClearFlag(clrF),
        .busOperateFlag(opF), .slaveEmulationFlag(emuF), .hostRunFlag(hostF),
        .busCommEnable(commEn), .procDataEnable(procEn),
        .outputDataEnable(outEn), .irq(irq));

    fbs_slave_model #(.NODES(N)) u_fbs_slave_model (.mclk(mclk), .nrst(nrst),
        .busCommEnable(commEn), .procDataEnable(procEn), .cfgExpected(cfgExpected),
        .nodePresent(nodePresent), .nodeFaulty(nodeFaulty), .slaveExpected(sExp),
        .slaveOnline(sOn), .slaveExchanging(sEx));

    always #2 mclk = ~mclk;

    task automatic test_done();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask

    // Hold the request until waitrequest is seen low, then release
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        avsRead  <= !wr;
        avsWrite <= wr;
        avsAddr  <= a;
        avsWdata <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (waitReq !== 1'b0 && n < 50);
        if (n >= 50)
            error_cnt++;
        q = avsRdata;
        avsRead  <= 1'b0;
        avsWrite <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic chk_state(input int st);
        chk_reg({28'h0, opF, clrF, stopF, offF}, 32'h1 << st);
        chk_bit(commEn, st != 0);
        chk_bit(procEn, st >= 2);
        chk_bit(outEn, st == 3);
        rd(`FBS_OFF_FLAGS, rdv);
        chk_reg(rdv & 32'h1e, 32'h2 << st);
    endtask

    initial begin
        #20000;
        error_cnt++;
        test_done();
    end

    initial begin
        mclk = 1'b0; nrst = 1'b0; avsRead = 1'b0; avsWrite = 1'b0; avsAddr = 5'h00;
        avsWdata = 32'h0; linkFault = 1'b0; cfgExpected = 8'h00;
        nodePresent = 8'hff; nodeFaulty = 8'h00; error_cnt = 0; checks = 0;
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        settle(1);
        chk_state(0);
        chk_bit(irq, 1'b0);
        rd(`FBS_OFF_CTRL, rdv);
        chk_reg(rdv, 32'h0);
        // Walk all four states, returning to offline
        for (s = 1; s <= 4; s++) begin
            wr(`FBS_OFF_CTRL, 32'(s % 4));
            settle(2);
            chk_state(s % 4);
        end
        // Host modes program, run and fault, slave emulation set in run mode only
        for (h = 0; h < 3; h++) begin
            wr(`FBS_OFF_CTRL, 32'((h << 4) | ((h & 1) << 2)));
            settle(2);
            chk_bit(hostF, h == 1);
            chk_bit(emuF, (h & 1) == 1);
            rd(`FBS_OFF_FLAGS, rdv);
            chk_reg(rdv & 32'h60, (h == 1) ? 32'h60 : 32'h00);
        end
        wr(`FBS_OFF_IRQ_CLEAR, 32'h7);
        wr(`FBS_OFF_IRQ_ENABLE, 32'h3);
        rd(`FBS_OFF_IRQ_STATUS, rdv);
        chk_reg(rdv, 32'h0);
        chk_bit(irq, 1'b0);
        // Device error: expected nodes faulty, absent, or not exchanging
        @(posedge mclk);
        cfgExpected <= 8'h0f;
        wr(`FBS_OFF_CTRL, 32'h3);
        settle(3);
        chk_bit(devErr, 1'b0);
        wr(`FBS_OFF_IRQ_CLEAR, 32'h7);
        settle(1);
        chk_bit(irq, 1'b0);
        @(posedge mclk);
        nodeFaulty <= 8'h20;
        settle(3);
        chk_bit(devErr, 1'b0);
        @(posedge mclk);
        nodeFaulty <= 8'h04;
        settle(3);
        chk_bit(devErr, 1'b1);
        chk_bit(irq, 1'b1);
        rd(`FBS_OFF_IRQ_STATUS, rdv);
        chk_reg(rdv & 32'h2, 32'h2);
        @(posedge mclk);
        nodeFaulty <= 8'h00;
        nodePresent <= 8'hf7;
        settle(3);
        chk_bit(devErr, 1'b1);
        @(posedge mclk);
        nodePresent <= 8'hff;
        wr(`FBS_OFF_CTRL, 32'h1);
        settle(3);
        chk_bit(devErr, 1'b1);
        // Interrupt masked, then cleared
        wr(`FBS_OFF_IRQ_ENABLE, 32'h0);
        settle(0);
        chk_bit(irq, 1'b0);
        wr(`FBS_OFF_IRQ_ENABLE, 32'h1);
        settle(0);
        chk_bit(irq, 1'b1);
        @(posedge mclk);
        cfgExpected <= 8'h00;
        wr(`FBS_OFF_IRQ_CLEAR, 32'h7);
        settle(1);
        chk_bit(irq, 1'b0);
        rd(`FBS_OFF_IRQ_STATUS, rdv);
        chk_reg(rdv, 32'h0);
        // Refused places read zero or ignore writes
        rd(`FBS_OFF_IRQ_CLEAR, rdv);
        chk_reg(rdv, 32'h0);
        wr(5'h14, 32'hff);
        rd(5'h14, rdv);
        chk_reg(rdv, 32'h0);
        wr(`FBS_OFF_FLAGS, 32'h7f);
        rd(`FBS_OFF_FLAGS, rdv);
        chk_reg(rdv & 32'h1e, 32'h4);
        // Link fault forces offline
        wr(`FBS_OFF_CTRL, 32'h3);
        settle(2);
        @(posedge mclk);
        linkFault <= 1'b1;
        settle(2);
        chk_state(0);
        chk_bit(irq, 1'b1);
        @(posedge mclk);
        linkFault <= 1'b0;
        settle(2);
        chk_state(3);
        test_done();
    end
endmodule
